// ===== design/privilege_mode_control.sv
// Privilege-mode control: mode flags, private-instruction tracking,
// request qualifiers, page-fail and interrupt entry sequencing.
// Assumes the memory controller and interrupt logic share clk_in.
`timescale 1ns/1ps
`default_nettype none
module privilege_mode_control
    import privilege_mode_pkg::*;
(
    input  wire logic          clk_in,
    input  wire logic          rst_in,
    input  wire logic          demand_paging_in,
    input  wire logic          request_in,
    input  wire logic          opcode_fetch_in,
    input  wire logic          memory_response_in,
    input  wire logic          memory_transfer_in,
    input  wire mem_attr_t     table_attr_in,
    input  wire logic          page_fail_hold_in,
    input  wire logic          portal_jump_in,
    input  wire logic          jump_restore_flags_in,
    input  wire logic          special_flag_function_in,
    input  wire logic          magic_bit04_in,
    input  wire flag_word_t    flag_word_in,
    input  wire sample_point_t sample_point_in,
    input  wire logic          interrupt_pending_in,
    input  wire logic          interrupt_ready_in,
    input  wire logic [2:0]    interrupt_level_in,
    input  wire logic          jump_to_subroutine_in,
    input  wire logic          write_test_ok_in,
    input  wire logic [17:0]   effective_address_in,
    output mode_t              mode_out,
    output logic               user_flag_out,
    output logic               user_io_flag_out,
    output logic               open_flag_out,
    output logic               private_instr_out,
    output logic               interrupt_cycle_flag_out,
    output req_qual_t          request_out,
    output logic               leave_user_out,
    output logic               access_fault_out,
    output logic               page_fault_report_out,
    output logic               interrupt_dispatch_out,
    output logic               vector_fetch_out,
    output logic [8:0]         vector_address_out,
    output logic               store_strobe_out,
    output logic [17:0]        store_address_out,
    output logic [17:0]        next_fetch_address_out
);

    typedef enum logic [1:0] {
        SEQ_RUN,
        SEQ_PF_ENTRY,
        SEQ_PI_WAIT,
        SEQ_PI_SET
    } seq_state_t;

    seq_state_t seq_q;
    seq_state_t seq_d;
    mode_t      mode_now;
    mode_t      mode_d;
    logic       fetch_xfer;
    logic       flag_load;
    logic       leave_user;
    logic       clear_open;
    logic       exec_mode;
    logic       user_set;
    logic       io_set;
    logic       open_set;
    logic       open_clr;
    logic       priv_set;
    logic       set_icyc;
    logic       illegal_d;
    req_qual_t  request_d;
    logic       report_d;
    logic       dispatch_d;
    logic       vfetch_d;
    logic [8:0] vaddr_d;
    logic       sampled;

    // Flag event decode from the current flags and microcode strobes
    always_comb begin
        fetch_xfer = memory_transfer_in & opcode_fetch_in;
        flag_load  = special_flag_function_in & magic_bit04_in;
        exec_mode  = ~user_flag_out;
        // Restore jump only leaves user from Kernel mode
        leave_user = (special_flag_function_in & interrupt_cycle_flag_out)
                   | (jump_restore_flags_in & flag_load
                      & (mode_now == MODE_KERNEL));
        // Supervisor restoring a concealed program
        clear_open = flag_load & exec_mode & open_flag_out
                   & flag_word_in.user & ~flag_word_in.open;
        user_set   = flag_load & exec_mode & flag_word_in.user;
        // Leaving user records previous-context user
        io_set     = (leave_user & user_flag_out)
                   | (flag_load & exec_mode & flag_word_in.user_io);
        // Public sets from the word, clears from it only via clear_open: Kernel restore
        // from Supervisor keeps public until a portal
        open_set   = flag_load & flag_word_in.open & ~clear_open;
        open_clr   = leave_user | clear_open
                   | (portal_jump_in & private_instr_out);
        // Fetch breaks the hold path and re-arms on a private source
        priv_set   = leave_user
                   | (fetch_xfer
                      & (~table_attr_in.open | ~open_flag_out));
        set_icyc   = (seq_q == SEQ_PI_SET);
    end

    // Mode flags; reset forces the leave-user values
    flag_cell #(.RESET_VAL(USER_RESET)) u_user (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .set_in (user_set),
        .clr_in (leave_user),
        .q_out  (user_flag_out)
    );
    flag_cell #(.RESET_VAL(USER_IO_RESET)) u_user_io (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .set_in (io_set),
        .clr_in (leave_user),
        .q_out  (user_io_flag_out)
    );
    flag_cell #(.RESET_VAL(OPEN_RESET)) u_open (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .set_in (open_set),
        .clr_in (open_clr),
        .q_out  (open_flag_out)
    );
    // Data accesses never touch the clear, so private holds
    flag_cell #(.RESET_VAL(PRIV_RESET)) u_private (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .set_in (priv_set),
        .clr_in (fetch_xfer),
        .q_out  (private_instr_out)
    );
    // Interrupt cycle ends once its leave-user has happened
    flag_cell #(.RESET_VAL(ICYC_RESET)) u_icyc (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .set_in (set_icyc),
        .clr_in (leave_user & interrupt_cycle_flag_out),
        .q_out  (interrupt_cycle_flag_out)
    );

    mode_decode u_mode_now (
        .user_in  (user_flag_out),
        .open_in  (open_flag_out),
        .mode_out (mode_now)
    );

    // Mode of the flags as they will be after this edge
    mode_decode u_mode_next (
        .user_in  (user_set | (user_flag_out & ~leave_user)),
        .open_in  (open_set | (open_flag_out & ~open_clr)),
        .mode_out (mode_d)
    );

    // Request qualifiers; illegal entry is masked in interrupt cycle
    always_comb begin
        illegal_d = open_flag_out & private_instr_out
                  & ~interrupt_cycle_flag_out;
        request_d.valid         = request_in;
        request_d.fetch         = request_in & opcode_fetch_in;
        // Concealed code has public clear, so data is never tested
        request_d.test_private  = request_in & open_flag_out
                                & ~opcode_fetch_in;
        request_d.address_open  = request_in & open_flag_out
                                & ~interrupt_cycle_flag_out;
        request_d.illegal_entry = request_in & illegal_d;
    end

    // Page-fail and interrupt entry sequencer
    always_comb begin
        seq_d      = seq_q;
        report_d   = 1'b0;
        dispatch_d = 1'b0;
        vfetch_d   = 1'b0;
        sampled    = (sample_point_in != SMP_NONE);
        vaddr_d    = VECTOR_BASE
                   + 9'({interrupt_level_in, 1'b0});
        unique case (seq_q)
            SEQ_RUN: begin
                if (page_fail_hold_in) begin
                    seq_d = SEQ_PF_ENTRY;
                end else if (sampled && interrupt_pending_in) begin
                    seq_d      = SEQ_PI_WAIT;
                    dispatch_d = 1'b1;
                end
            end
            SEQ_PF_ENTRY: begin
                // Interrupt outranks the page fault
                if (interrupt_pending_in) begin
                    seq_d      = SEQ_PI_WAIT;
                    dispatch_d = 1'b1;
                end else begin
                    seq_d    = SEQ_RUN;
                    report_d = 1'b1;
                end
            end
            SEQ_PI_WAIT: begin
                // Interrupt logic finishes its handshake first
                if (interrupt_ready_in) begin
                    seq_d = SEQ_PI_SET;
                end
            end
            SEQ_PI_SET: begin
                seq_d    = SEQ_RUN;
                vfetch_d = 1'b1;
            end
        endcase
    end

    // Registered outputs; every output leaves from a flop
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            seq_q                  <= SEQ_RUN;
            mode_out               <= MODE_KERNEL;
            request_out            <= '0;
            leave_user_out         <= 1'b0;
            access_fault_out       <= 1'b0;
            page_fault_report_out  <= 1'b0;
            interrupt_dispatch_out <= 1'b0;
            vector_fetch_out       <= 1'b0;
            vector_address_out     <= VECTOR_BASE;
            store_strobe_out       <= 1'b0;
            store_address_out      <= '0;
            next_fetch_address_out <= '0;
        end else begin
            seq_q                  <= seq_d;
            mode_out               <= mode_d;
            request_out            <= request_d;
            leave_user_out         <= leave_user;
            // Absent page under demand paging
            access_fault_out       <= demand_paging_in & memory_response_in
                                    & ~table_attr_in.in_core;
            page_fault_report_out  <= report_d;
            interrupt_dispatch_out <= dispatch_d;
            vector_fetch_out       <= vfetch_d;
            vector_address_out     <= vaddr_d;
            // Store only after a passing write
            store_strobe_out <= jump_to_subroutine_in & write_test_ok_in;
            if (jump_to_subroutine_in && write_test_ok_in) begin
                store_address_out      <= effective_address_in;
                next_fetch_address_out <= effective_address_in
                                        + SUB_ENTRY_STEP;
            end
        end
    end

    // Checks on the mode and sequencing behaviour
    property p_private_set;
        @(posedge clk_in) disable iff (rst_in)
        fetch_xfer && !table_attr_in.open |=> private_instr_out;
    endproperty
    a_private_set: assert property (p_private_set)
        else $error("private not set after private fetch");

    property p_portal;
        @(posedge clk_in) disable iff (rst_in)
        portal_jump_in && private_instr_out && user_flag_out
        && !flag_load && !leave_user |=> mode_out == MODE_CONCEALED;
    endproperty
    a_portal: assert property (p_portal)
        else $error("portal did not enter concealed mode");

    property p_illegal;
        @(posedge clk_in) disable iff (rst_in)
        request_out.illegal_entry |->
            $past(open_flag_out) && $past(private_instr_out)
            && !$past(interrupt_cycle_flag_out);
    endproperty
    a_illegal: assert property (p_illegal)
        else $error("illegal entry without public private cause");

    property p_test_private;
        @(posedge clk_in) disable iff (rst_in)
        request_in && open_flag_out |=>
            request_out.test_private == !$past(opcode_fetch_in);
    endproperty
    a_test_private: assert property (p_test_private)
        else $error("test private qualifier wrong");

    property p_clear_open;
        @(posedge clk_in) disable iff (rst_in)
        mode_now == MODE_SUPERVISOR && flag_load && flag_word_in.user
        && !flag_word_in.open && !leave_user
        |=> mode_out == MODE_CONCEALED ##1 mode_now == MODE_CONCEALED;
    endproperty
    a_clear_open: assert property (p_clear_open)
        else $error("supervisor restore did not reach concealed");

    property p_no_leave;
        @(posedge clk_in) disable iff (rst_in)
        mode_now != MODE_KERNEL && !interrupt_cycle_flag_out
        |=> !leave_user_out;
    endproperty
    a_no_leave: assert property (p_no_leave)
        else $error("leave user outside kernel or interrupt cycle");

    property p_pf_priority;
        @(posedge clk_in) disable iff (rst_in)
        seq_q == SEQ_RUN && page_fail_hold_in ##1 interrupt_pending_in
        |=> interrupt_dispatch_out && !page_fault_report_out;
    endproperty
    a_pf_priority: assert property (p_pf_priority)
        else $error("page fault reported over pending interrupt");

    property p_pf_report;
        @(posedge clk_in) disable iff (rst_in)
        seq_q == SEQ_RUN && page_fail_hold_in ##1 !interrupt_pending_in
        |=> page_fault_report_out;
    endproperty
    a_pf_report: assert property (p_pf_report)
        else $error("page fault not reported");

    property p_vector;
        @(posedge clk_in) disable iff (rst_in)
        seq_q == SEQ_PI_WAIT && interrupt_ready_in
        |=> ##1 vector_fetch_out && interrupt_cycle_flag_out
            && !request_d.illegal_entry
            && vector_address_out == 9'h020 + 9'({$past(
               interrupt_level_in), 1'b0});
    endproperty
    a_vector: assert property (p_vector)
        else $error("vector fetch wrong or unmasked");

    property p_leave_user;
        @(posedge clk_in) disable iff (rst_in)
        special_flag_function_in && interrupt_cycle_flag_out
        && !magic_bit04_in
        |=> mode_now == MODE_KERNEL
            && user_io_flag_out == $past(user_flag_out);
    endproperty
    a_leave_user: assert property (p_leave_user)
        else $error("leave user did not enter kernel");

    property p_jsr;
        @(posedge clk_in) disable iff (rst_in)
        jump_to_subroutine_in && write_test_ok_in
        |=> store_strobe_out
            && next_fetch_address_out == 18'($past(effective_address_in) + 1);
    endproperty
    a_jsr: assert property (p_jsr)
        else $error("subroutine entry address wrong");

    property p_access_fault;
        @(posedge clk_in) disable iff (rst_in)
        demand_paging_in && memory_response_in && !table_attr_in.in_core
        |=> access_fault_out;
    endproperty
    a_access_fault: assert property (p_access_fault)
        else $error("missing access fault");

    c_portal: cover property (@(posedge clk_in) disable iff (rst_in)
        mode_now == MODE_PUBLIC ##1 mode_now == MODE_CONCEALED);
    c_vector: cover property (@(posedge clk_in) disable iff (rst_in)
        vector_fetch_out ##[1:20] leave_user_out);
    c_report: cover property (@(posedge clk_in) disable iff (rst_in)
        page_fault_report_out);

endmodule
`default_nettype wire

// ===== design/privilege_mode_pkg.sv
// Shared types and constants for the privilege-mode control block.
// Assumes one processor clock; all partners are clocked logic on it.
package privilege_mode_pkg;

    // Kernel vector area: interrupt level n fetches from base + 2n
    localparam logic [8:0]  VECTOR_BASE     = 9'h020;
    localparam int          VECTOR_STEP_LOG = 1;
    localparam int          ADDR_W          = 18;
    localparam logic [17:0] SUB_ENTRY_STEP  = 18'h00001;

    // Reset values of the mode flags (Kernel, private set)
    localparam logic USER_RESET    = 1'b0;
    localparam logic USER_IO_RESET = 1'b0;
    localparam logic OPEN_RESET    = 1'b0;
    localparam logic PRIV_RESET    = 1'b1;
    localparam logic ICYC_RESET    = 1'b0;

    // Mode from the user and public flags
    typedef enum logic [1:0] {
        MODE_KERNEL,
        MODE_SUPERVISOR,
        MODE_CONCEALED,
        MODE_PUBLIC
    } mode_t;

    // Points at which the microcode may sample interrupts
    typedef enum logic [2:0] {
        SMP_NONE,
        SMP_BETWEEN,
        SMP_BYTE,
        SMP_BLOCK,
        SMP_IO,
        SMP_INDIRECT
    } sample_point_t;

    // Page-table use attributes returned with a response
    typedef struct packed {
        logic in_core;
        logic writable;
        logic open;
        logic cacheable;
    } mem_attr_t;

    // Flag word from the adder: bits 05, 06, 07
    typedef struct packed {
        logic user;
        logic user_io;
        logic open;
    } flag_word_t;

    // Qualifiers sent with a memory request
    typedef struct packed {
        logic valid;
        logic fetch;
        logic test_private;
        logic address_open;
        logic illegal_entry;
    } req_qual_t;

endpackage

// ===== design/flag_cell.sv
// One mode flag with hold path, set and clear; set wins over clear.
// Assumes synchronous active-high reset on the processor clock.
`timescale 1ns/1ps
`default_nettype none
module flag_cell #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic set_in,
    input  wire logic clr_in,
    output logic      q_out
);
    logic flag_d;

    // Clear breaks the hold path; a set in the same cycle still lands
    always_comb begin
        flag_d = set_in | (q_out & ~clr_in);
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            q_out <= RESET_VAL;
        end else begin
            q_out <= flag_d;
        end
    end
endmodule
`default_nettype wire

// ===== design/mode_decode.sv
// Maps the user and public flags onto the four processor modes.
// Pure combinational; the caller registers the u_mode_next result only.
`timescale 1ns/1ps
`default_nettype none
module mode_decode
    import privilege_mode_pkg::*;
(
    input  wire logic  user_in,
    input  wire logic  open_in,
    output mode_t      mode_out
);
    // Two flags give four modes
    always_comb begin
        unique case ({user_in, open_in})
            2'b00:   mode_out = MODE_KERNEL;
            2'b01:   mode_out = MODE_SUPERVISOR;
            2'b10:   mode_out = MODE_CONCEALED;
            2'b11:   mode_out = MODE_PUBLIC;
        endcase
    end
endmodule
`default_nettype wire

// ===== testbench/far_side_model.sv
// Far-side model: memory controller and interrupt logic facing the
// privilege-mode block. Assumes the shared clock and sync reset.
`timescale 1ns/1ps
`default_nettype none
module far_side_model
    import privilege_mode_pkg::*;
#(
    parameter int READY_DELAY = 3
) (
    input  wire logic      clk_in,
    input  wire logic      rst_in,
    input  wire req_qual_t request_in,
    input  wire logic      dispatch_in,
    input  wire logic      page_open_in,
    input  wire logic      page_in_core_in,
    output logic           response_out,
    output logic           transfer_out,
    output mem_attr_t      attr_out,
    output logic           hold_out,
    output logic           ready_out
);
    logic [3:0] refill_q;
    int         ready_q;

    // Table check, refill and answer; idle attributes scramble so that
    // a stale value is never taken for a fresh one
    always_ff @(posedge clk_in) begin
        response_out <= 1'h0;
        transfer_out <= 1'h0;
        hold_out     <= 1'h0;
        ready_out    <= 1'h0;
        attr_out     <= ~attr_out;
        if (rst_in) begin
            refill_q <= 4'h0;
            ready_q  <= 0;
            attr_out <= 4'h5;
        end else begin
            // Concealed entry or concealed data touch fails at the check
            if (request_in.valid) begin
                if (request_in.illegal_entry ||
                    (request_in.test_private && !page_open_in))
                    hold_out <= 1'h1;
                else
                    refill_q <= page_in_core_in ? 4'h1 : 4'h8;
            end else if (refill_q != 4'h0) begin
                refill_q <= refill_q - 4'h1;
                if (refill_q == 4'h1) begin
                    response_out <= 1'h1;
                    transfer_out <= 1'h1;
                    attr_out <= {page_in_core_in, 1'h1,
                                 page_open_in, 1'h1};
                end
            end
            // Ready only once the handshake delay has run out
            if (dispatch_in)
                ready_q <= READY_DELAY;
            else if (ready_q != 0) begin
                ready_q <= ready_q - 1;
                if (ready_q == 1)
                    ready_out <= 1'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for privilege_mode_control and its far side.
// Assumes the package, design files and far-side model compile first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import privilege_mode_pkg::*;

    typedef struct packed {
        logic       rst;
        flag_word_t word;
        mode_t      mode;
        logic       io;
        logic       leave;
    } row_t;

    logic          clk_in, rst_in, dp, req, fetch, portal, restore;
    logic          special, bit04, pend, jump_to_subroutine, wtok, pg_open, pg_core;
    logic          resp, xfer, pfh, ready, user, io, open, priv, icyc;
    logic          leave, afault, pfrep, disp, vfetch, strobe;
    logic [2:0]    level;
    logic [8:0]    vaddr, va_seen;
    logic [17:0]   ea, saddr, naddr;
    flag_word_t    word;
    mode_t         mode;
    mem_attr_t     attr;
    sample_point_t smp;
    req_qual_t     rq, last_rq;
    int            errors, cmp_count, n_lv, n_pf, n_ds, n_af, n_ans, n_vf;
    row_t          rows [7] = '{
        '{1'h1, 3'h1, MODE_SUPERVISOR, 1'h0, 1'h1},
        '{1'h0, 3'h4, MODE_CONCEALED, 1'h0, 1'h0},
        '{1'h1, 3'h1, MODE_SUPERVISOR, 1'h0, 1'h1},
        '{1'h0, 3'h5, MODE_PUBLIC, 1'h0, 1'h0},
        '{1'h1, 3'h6, MODE_CONCEALED, 1'h1, 1'h1},
        '{1'h1, 3'h1, MODE_SUPERVISOR, 1'h0, 1'h1},
        '{1'h0, 3'h0, MODE_SUPERVISOR, 1'h0, 1'h0}
    };

    privilege_mode_control u_dut (.clk_in(clk_in), .rst_in(rst_in),
        .demand_paging_in(dp), .request_in(req), .opcode_fetch_in(fetch),
        .memory_response_in(resp), .memory_transfer_in(xfer),
        .table_attr_in(attr), .page_fail_hold_in(pfh),
        .portal_jump_in(portal), .jump_restore_flags_in(restore),
        .special_flag_function_in(special), .magic_bit04_in(bit04),
        .flag_word_in(word), .sample_point_in(smp),
        .interrupt_pending_in(pend), .interrupt_ready_in(ready),
        .interrupt_level_in(level), .jump_to_subroutine_in(jump_to_subroutine),
        .write_test_ok_in(wtok), .effective_address_in(ea),
        .mode_out(mode), .user_flag_out(user), .user_io_flag_out(io),
        .open_flag_out(open), .private_instr_out(priv),
        .interrupt_cycle_flag_out(icyc), .request_out(rq),
        .leave_user_out(leave), .access_fault_out(afault),
        .page_fault_report_out(pfrep), .interrupt_dispatch_out(disp),
        .vector_fetch_out(vfetch), .vector_address_out(vaddr),
        .store_strobe_out(strobe), .store_address_out(saddr),
        .next_fetch_address_out(naddr));

    far_side_model #(.READY_DELAY(3)) u_far (.clk_in(clk_in),
        .rst_in(rst_in), .request_in(rq), .dispatch_in(disp),
        .page_open_in(pg_open), .page_in_core_in(pg_core),
        .response_out(resp), .transfer_out(xfer), .attr_out(attr),
        .hold_out(pfh), .ready_out(ready));

    // Clock at 8 ns period
    always #4 clk_in = ~clk_in;

    // Pulse counters; a pulse is counted once, one edge late
    always @(posedge clk_in) begin
        n_lv += int'(leave);
        n_pf += int'(pfrep);
        n_ds += int'(disp);
        n_af += int'(afault);
        n_ans += int'(resp) + 2 * int'(pfh); // A hold counts double
        n_vf += int'(vfetch);
        if (vfetch)
            va_seen = vaddr;
    end

    task automatic chk(input string nm, input logic [17:0] exp,
                       input logic [17:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Bounded wait on a pulse counter; a run-out counts as a mismatch
    task automatic wait_for(ref int c);
        int n;
        n = 0;
        while (c == 0 && n < 40) begin
            @(negedge clk_in);
            n++;
        end
        chk("wait", 18'h00001, 18'(c != 0));
    endtask

    task automatic do_reset();
        rst_in = 1'h1;
        repeat (12) @(negedge clk_in);
        rst_in = 1'h0;
    endtask

    task automatic load(input flag_word_t w, input logic rj);
        @(negedge clk_in);
        restore = rj;
        special = 1'h1;
        bit04 = rj;
        word = w;
        @(negedge clk_in);
        restore = 1'h0;
        special = 1'h0;
        bit04 = 1'h0;
    endtask

    // Opcode-fetch qualifier is held until the far side answers
    task automatic mem(input logic f);
        n_ans = 0;
        @(negedge clk_in);
        req = 1'h1;
        fetch = f;
        @(negedge clk_in);
        req = 1'h0;
        last_rq = rq;
        wait_for(n_ans);
        @(negedge clk_in);
        fetch = 1'h0;
    endtask

    task automatic pulse_portal();
        @(negedge clk_in);
        portal = 1'h1;
        @(negedge clk_in);
        portal = 1'h0;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_in);
        errors++;
        conclude();
    end

    initial begin
        clk_in = 1'h0;
        {rst_in, dp, req, fetch, portal, restore, special} = 7'h40;
        {bit04, pend, jump_to_subroutine, wtok, pg_open, pg_core} = 6'h03;
        word = 3'h0;
        smp = SMP_NONE;
        level = 3'h3;
        ea = 18'h3FFFF;
        do_reset();
        chk("reset", 18'h2, 18'({mode, user, io, open, priv, icyc}));
        $display("test reset done");
        // Flag-load table; Supervisor pair restores then holds public
        foreach (rows[i]) begin
            if (rows[i].rst)
                do_reset();
            n_lv = 0;
            load(rows[i].word, 1'h1);
            repeat (2) @(negedge clk_in);
            chk("mode", 18'(rows[i].mode), 18'(mode));
            chk("user_io", 18'(rows[i].io), 18'(io));
            chk("leave", 18'(rows[i].leave), 18'(n_lv));
        end
        pulse_portal();
        chk("portal_mode", 18'(MODE_KERNEL), 18'(mode));
        $display("test flag_table done");
        // Public data while private is still set: illegal entry faults
        do_reset();
        load(3'h1, 1'h1);
        load(3'h5, 1'h1);
        n_pf = 0;
        mem(1'h0);
        chk("illegal", 18'h00001, 18'(last_rq.illegal_entry));
        chk("test_priv", 18'h00001, 18'(last_rq.test_private));
        repeat (3) @(negedge clk_in);
        chk("pf_report", 18'h00001, 18'(n_pf));
        pulse_portal();
        chk("concealed", 18'(MODE_CONCEALED), 18'(mode));
        mem(1'h0);
        chk("open_data", 18'h10, 18'(last_rq));
        chk("open_ans", 18'h1, 18'(n_ans));
        $display("test portal done");
        // Demand paging with a slow refill answering not in core
        do_reset();
        dp = 1'h1;
        pg_core = 1'h0;
        n_af = 0;
        mem(1'h0);
        repeat (2) @(negedge clk_in);
        chk("access_fault", 18'h00001, 18'(n_af));
        chk("priv_data", 18'h00001, 18'(priv));
        dp = 1'h0;
        pg_core = 1'h1;
        $display("test demand_paging done");
        // Every interrupt sample point dispatches
        for (int k = 1; k < 6; k++) begin
            do_reset();
            n_ds = 0;
            smp = sample_point_t'(k);
            pend = 1'h1;
            wait_for(n_ds);
            smp = SMP_NONE;
            pend = 1'h0;
        end
        $display("test sample_points done");
        // Interrupt out of User Public, vector, subroutine, leave-user
        do_reset();
        load(3'h1, 1'h1);
        load(3'h5, 1'h1);
        n_ds = 0;
        n_vf = 0;
        smp = SMP_BETWEEN;
        pend = 1'h1;
        wait_for(n_ds);
        smp = SMP_NONE;
        pend = 1'h0;
        wait_for(n_vf);
        chk("vector", 18'h00026, 18'(va_seen));
        chk("icyc", 18'h00001, 18'(icyc));
        mem(1'h1);
        chk("icyc_qual", 18'h18, 18'(last_rq));
        chk("icyc_ans", 18'h1, 18'(n_ans));
        chk("priv_public_page", 18'h00000, 18'(priv));
        pg_open = 1'h0;
        mem(1'h1);
        chk("priv_private_page", 18'h00001, 18'(priv));
        @(negedge clk_in);
        jump_to_subroutine = 1'h1;
        wtok = 1'h1;
        @(negedge clk_in);
        jump_to_subroutine = 1'h0;
        wtok = 1'h0;
        chk("jsr", 18'h00001, 18'(strobe));
        chk("jsr_store", ea, saddr);
        chk("jsr_next", 18'h00000, naddr);
        n_lv = 0;
        load(3'h0, 1'h0);
        chk("kernel", 18'h4, 18'({mode, user, io, open, icyc}));
        @(negedge clk_in);
        chk("leave_icyc", 18'h00001, 18'(n_lv));
        $display("test interrupt done");
        // Page fail while an interrupt waits goes to the interrupt
        do_reset();
        load(3'h1, 1'h1);
        load(3'h5, 1'h1);
        pend = 1'h1;
        n_ds = 0;
        n_pf = 0;
        mem(1'h0);
        repeat (3) @(negedge clk_in);
        pend = 1'h0;
        chk("pf_priority", 18'h00002, 18'({n_ds == 1, n_pf != 0}));
        $display("test priority done");
        conclude();
    end
endmodule
`default_nettype wire
